// *** hw/pwm_pkg.sv ***
package pwm_pkg;

  // ***************************************************************
  // register map (byte addresses, one aligned word each)
  // ***************************************************************
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] PRE_OFS   = 8'h04;
  localparam logic [7:0] DUTY_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS  = 8'h0C;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_SRC_BIT  = 1;
  localparam int unsigned CTRL_PIN_BIT  = 2;
  localparam int unsigned STAT_RUN_BIT  = 0;
  localparam int unsigned STAT_LVL_BIT  = 1;
  localparam int unsigned STAT_LOW_BIT  = 2;
  localparam int unsigned STAT_STEP_LSB = 8;

  // ***************************************************************
  // reset values and counts
  // ***************************************************************
  localparam logic [2:0]  CTRL_RST  = 3'h0;
  localparam logic [7:0]  PRE_RST   = 8'h00;
  localparam logic [7:0]  DUTY_RST  = 8'h00;
  // step counter runs 0..254, i.e. 255 steps per period
  localparam logic [7:0]  STEP_LAST = 8'hFE;

  // ***************************************************************
  // bus encodings
  // ***************************************************************
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;

  // gray along idle -> low -> run
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_RUN  = 2'b11
  } pwm_state_e;

endpackage

// *** hw/pwm_top.sv ***
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pwm_top
  import pwm_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  // clock, reset, freeze
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // shared pins
  output logic             pulse_output_a,
  output logic             pulse_output_b
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  // address compare shared by the write and read decoders
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // a period opens high unless its duty is zero
  function automatic logic opens_high(input logic [DATA_W-1:0] m);
    opens_high = (m != '0);
  endfunction

  function automatic logic [31:0] zext(input logic [DATA_W-1:0] v);
    zext = {{(32-DATA_W){1'b0}}, v};
  endfunction

  // start-low count, in core clocks minus one
  function automatic logic [DATA_W-1:0] low_len(input logic [DATA_W-1:0] n,
                                                  input logic              src);
    if (src) begin
      low_len = n;
    end else begin
      low_len = {1'b0, n[DATA_W-1:1]};
    end
  endfunction

  // ***************************************************************
  // bus front end
  // ***************************************************************
  // bus state
  logic             wr_pend_r, wr_pend_nxt;
  logic [7:0]       wr_addr_r, wr_addr_nxt;
  logic [31:0]      rdata_r,   rdata_nxt;
  logic [2:0]       ctrl_r,    ctrl_nxt;
  logic [DATA_W-1:0] pre_r,    pre_nxt;
  logic [DATA_W-1:0] duty_r,   duty_nxt;
  logic             addr_ok;
  logic [31:0]      stat_word;
  logic [31:0]      rd_word;

  // engine state
  pwm_state_e        state_r, state_nxt;
  logic [DATA_W-1:0] low_cnt_r, low_cnt_nxt;
  logic [DATA_W-1:0] pre_cnt_r, pre_cnt_nxt;
  logic [7:0]        step_r,    step_nxt;
  logic [DATA_W-1:0] n_act_r,   n_act_nxt;
  logic [DATA_W-1:0] m_act_r,   m_act_nxt;
  logic              half_r,    half_nxt;
  logic              lvl_r,     lvl_nxt;
  logic              out_a_r,   out_a_nxt;
  logic              out_b_r,   out_b_nxt;
  logic              tick;

  // the bus is frozen together with the rest of the block
  assign hreadyout = ce;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = rdata_r;

  // hsize is accepted as is: only whole-word transfers are expected
  // seq is taken like nonseq; bursts are not expected but do no harm
  assign addr_ok = hsel & hready & ce & (htrans == HTRANS_NONSEQ || htrans == 2'h3);

  // ***************************************************************
  // status and read mux
  // ***************************************************************
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[STAT_RUN_BIT] = (state_r == ST_RUN);
    stat_word[STAT_LVL_BIT] = lvl_r;
    stat_word[STAT_LOW_BIT] = (state_r == ST_LOW);
    stat_word[STAT_STEP_LSB +: 8] = step_r;
  end

  always_comb begin
    if (hit(haddr[7:0], CTRL_OFS)) begin
      rd_word = {29'h0000_0000, ctrl_r};
    end else if (hit(haddr[7:0], PRE_OFS)) begin
      rd_word = zext(pre_r);
    end else if (hit(haddr[7:0], DUTY_OFS)) begin
      rd_word = zext(duty_r);
    end else if (hit(haddr[7:0], STAT_OFS)) begin
      rd_word = stat_word;
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  // ***************************************************************
  // register write and read
  // ***************************************************************
  always_comb begin
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt   = rdata_r;
    ctrl_nxt    = ctrl_r;
    pre_nxt     = pre_r;
    duty_nxt    = duty_r;
    // data phase of an earlier write
    if (wr_pend_r) begin
      if (hit(wr_addr_r, CTRL_OFS)) begin
        ctrl_nxt = hwdata[2:0];
      end else if (hit(wr_addr_r, PRE_OFS)) begin
        pre_nxt = hwdata[DATA_W-1:0];
      end else if (hit(wr_addr_r, DUTY_OFS)) begin
        duty_nxt = hwdata[DATA_W-1:0];
      end
    end
    // address phase: read data is sampled here and stands in the data phase
    if (addr_ok) begin
      wr_pend_nxt = hwrite;
      wr_addr_nxt = {haddr[7:2], 2'b00};
      if (!hwrite) begin
        rdata_nxt = rd_word;
      end
    end
  end

  // a low ce also holds hreadyout low, so no transfer is lost while frozen
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
      ctrl_r    <= CTRL_RST;
      pre_r     <= PRE_RST;
      duty_r    <= DUTY_RST;
    end else if (ce) begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r   <= rdata_nxt;
      ctrl_r    <= ctrl_nxt;
      pre_r     <= pre_nxt;
      duty_r    <= duty_nxt;
    end
  end

  // ***************************************************************
  // pulse engine
  // ***************************************************************
  // source select 1 counts every main clock, 0 every second one
  assign tick = ctrl_r[CTRL_SRC_BIT] | half_r;

  // the halving phase only runs inside a period, so each period starts alike
  always_comb begin
    half_nxt = 1'b0;
    if (ctrl_r[CTRL_EN_BIT] && state_r == ST_RUN) begin
      half_nxt = ~half_r & ~ctrl_r[CTRL_SRC_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      half_r <= 1'b0;
    end else if (ce) begin
      half_r <= half_nxt;
    end
  end

  always_comb begin
    state_nxt   = state_r;
    low_cnt_nxt = low_cnt_r;
    pre_cnt_nxt = pre_cnt_r;
    step_nxt    = step_r;
    n_act_nxt   = n_act_r;
    m_act_nxt   = m_act_r;
    lvl_nxt     = lvl_r;
    if (!ctrl_r[CTRL_EN_BIT]) begin
      state_nxt   = ST_IDLE;
      lvl_nxt     = 1'b0;
      pre_cnt_nxt = '0;
      step_nxt    = 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // enable seen: reinitialise, hold the pin low first
          state_nxt = ST_LOW;
          lvl_nxt   = 1'b0;
          low_cnt_nxt = low_len(pre_r, ctrl_r[CTRL_SRC_BIT]);
        end
        ST_LOW: begin
          // the low count was fixed at enable; later prescaler writes wait
          if (low_cnt_r == '0) begin
            state_nxt   = ST_RUN;
            n_act_nxt   = pre_r;
            m_act_nxt   = duty_r;
            pre_cnt_nxt = '0;
            step_nxt    = 8'h00;
            // first period opens high unless the duty is zero
            lvl_nxt     = opens_high(duty_r);
          end else begin
            low_cnt_nxt = low_cnt_r - 1'b1;
          end
        end
        ST_RUN: begin
          if (tick) begin
            if (pre_cnt_r == n_act_r) begin
              pre_cnt_nxt = '0;
              if (step_r == STEP_LAST) begin
                step_nxt  = 8'h00;
                // shadows load only at the period boundary
                n_act_nxt = pre_r;
                m_act_nxt = duty_r;
                lvl_nxt   = opens_high(duty_r);
              end else begin
                step_nxt = step_r + 8'h01;
                lvl_nxt  = ((step_r + 8'h01) < m_act_r);
              end
            end else begin
              pre_cnt_nxt = pre_cnt_r + 1'b1;
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          lvl_nxt   = 1'b0;
        end
      endcase
    end
  end

  // shadows n_act and m_act hold the running period's own settings
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r   <= ST_IDLE;
      low_cnt_r <= '0;
      pre_cnt_r <= '0;
      step_r    <= 8'h00;
      n_act_r   <= '0;
      m_act_r   <= '0;
      lvl_r     <= 1'b0;
    end else if (ce) begin
      state_r   <= state_nxt;
      low_cnt_r <= low_cnt_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      step_r    <= step_nxt;
      n_act_r   <= n_act_nxt;
      m_act_r   <= m_act_nxt;
      lvl_r     <= lvl_nxt;
    end
  end

  // ***************************************************************
  // pin routing
  // ***************************************************************
  // the unselected pin stays low so its port function is undisturbed
  // outputs come straight from flops so the pins never glitch
  always_comb begin
    out_a_nxt = lvl_nxt & ~ctrl_nxt[CTRL_PIN_BIT];
    out_b_nxt = lvl_nxt &  ctrl_nxt[CTRL_PIN_BIT];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
    end else if (ce) begin
      out_a_r <= out_a_nxt;
      out_b_r <= out_b_nxt;
    end
  end

  assign pulse_output_a = out_a_r;
  assign pulse_output_b = out_b_r;

endmodule

`default_nettype wire

// *** verif/pwm_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module pwm_chk
  import pwm_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  // pins
  input wire logic        pulse_output_a,
  input wire logic        pulse_output_b
);
  logic       wv_r;
  logic [7:0] wa_r;
  logic [2:0] ctl_r;
  logic [7:0] pre_r;
  logic [7:0] duty_r;
  logic       lvl;
  assign lvl = pulse_output_a | pulse_output_b;

  // shadow of written fields; hready gates the address phase only, write data is taken the next cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wv_r <= 1'b0;
      wa_r <= 8'h00;
      ctl_r <= 3'h0;
      pre_r <= 8'h00;
      duty_r <= 8'h00;
    end else begin
      wv_r <= hsel && hready && htrans[1] && hwrite;
      wa_r <= haddr[7:0];
      if (wv_r && wa_r == CTRL_OFS) ctl_r <= hwdata[2:0];
      if (wv_r && wa_r == PRE_OFS) pre_r <= hwdata[7:0];
      if (wv_r && wa_r == DUTY_OFS) duty_r <= hwdata[7:0];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_EXCL: assert property (!(pulse_output_a && pulse_output_b))
    else $error("both pins high");
  AST_PIN_A: assert property (ctl_r[2] [*2] |-> !pulse_output_a)
    else $error("pin a active while b selected");
  AST_PIN_B: assert property (!ctl_r[2] [*2] |-> !pulse_output_b)
    else $error("pin b active while a selected");
  AST_OFF: assert property (!ctl_r[0] [*2] |-> !lvl)
    else $error("output high while disabled");
  AST_START_LOW: assert property ($rose(ctl_r[0]) |-> !lvl [*2])
    else $error("no low phase after enable");
  AST_FIRST_HIGH: assert property ($rose(ctl_r[0]) && ctl_r[1] && pre_r == 8'h00
    && duty_r != 8'h00 |-> ##2 lvl) else $error("first pulse not high");
  AST_ONE_HIGH: assert property ($rose(lvl) && ctl_r[1] && pre_r == 8'h00
    && duty_r == 8'h01 |=> !lvl) else $error("high time wrong");
  AST_LOW_RUN: assert property ($fell(lvl) && ctl_r[0] && ctl_r[1] && pre_r == 8'h00
    && duty_r == 8'h01 |-> !lvl [*8]) else $error("low time too short");

  cover property ($rose(ctl_r[0]));
  cover property ($rose(pulse_output_a));
  cover property ($rose(pulse_output_b));
endmodule

bind pwm_top pwm_chk chk_u (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .pulse_output_a(pulse_output_a), .pulse_output_b(pulse_output_b));

`default_nettype wire

// *** verif/pin_load.sv ***
`timescale 1ns/1ps
`default_nettype none

// load on the pin: reports high time and period of each whole pulse
module pin_load (
  // observation
  input  wire logic        core_clk,
  input  wire logic        clr,
  input  wire logic        pin,
  // measurement
  output logic             meas_v,
  output logic      [39:0] meas
);
  logic [19:0] cnt_r;
  logic [19:0] hi_r;
  logic        last_r;
  logic        seen_r;

  // first rise after clear only starts timing; its period is not whole
  always_ff @(posedge core_clk) begin
    meas_v <= 1'b0;
    last_r <= pin;
    cnt_r <= cnt_r + 20'h1;
    if (pin && !last_r) begin
      meas <= {hi_r, cnt_r};
      meas_v <= seen_r;
      cnt_r <= 20'h1;
      hi_r <= 20'h1;
      seen_r <= 1'b1;
    end else if (pin) begin
      hi_r <= hi_r + 20'h1;
    end
    if (clr) begin
      seen_r <= 1'b0;
      cnt_r <= 20'h0;
    end
  end
endmodule

`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb import pwm_pkg::*;;
  logic        core_clk, resetn, ce, hsel, hwrite, clr, rd_pend, meas_v;
  logic        hreadyout, hresp, pa, pb;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, lf;
  logic [39:0] meas;
  logic [39:0] rq[$];
  logic [39:0] pq[$];
  int          n_mismatch, comparisons;

  pwm_top dut_u (.core_clk(core_clk), .resetn(resetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pulse_output_a(pa),
    .pulse_output_b(pb));
  pin_load ld_u (.core_clk(core_clk), .clr(clr), .pin(pa | pb), .meas_v(meas_v), .meas(meas));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] nxt_lf(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h80200003 : 32'h0);
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rd_pend <= ~w;
    wait_rdy();
    rd_pend <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back({8'h0, exp});
    bus(a, 1'b0, lf);
  endtask

  task automatic pq_wait(input int n);
    int i;
    i = 0;
    while (pq.size() > n && i < 5000) begin
      @(posedge core_clk);
      i++;
    end
    if (pq.size() > n) begin
      n_mismatch++;
      test_done();
    end
  endtask

  always @(posedge core_clk) begin
    if (rd_pend && hreadyout) chk({8'h0, hrdata}, rq.pop_front());
    if (meas_v && pq.size() > 0) chk(meas, pq.pop_front());
  end

  initial begin
    logic [7:0]  cn[3];
    logic [7:0]  cm[3];
    logic [2:0]  cc[3];
    logic [19:0] u;
    cn = '{8'h00, 8'h02, 8'h01};
    cm = '{8'h01, 8'h05, 8'h02};
    cc = '{3'h3, 3'h7, 3'h1};
    {resetn, hsel, hwrite, rd_pend, htrans, haddr, hwdata} = '0;
    {ce, clr} = 2'b11;
    lf = 32'hAE25;
    n_mismatch = 0;
    comparisons = 0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    rd(CTRL_OFS, 32'h0);
    rd(DUTY_OFS, 32'h0);
    rd(8'h10, 32'h0);
    rd(STAT_OFS, 32'h0);
    repeat (3) begin
      lf = nxt_lf(lf);
      bus(PRE_OFS, 1'b1, lf);
      rd(PRE_OFS, {24'h0, lf[7:0]});
    end
    ce <= 1'b0;
    fork
      bus(PRE_OFS, 1'b1, 32'h5A);
      begin
        repeat (3) @(posedge core_clk);
        ce <= 1'b1;
      end
    join
    rd(PRE_OFS, 32'h5A);
    $display("test registers done");
    // table: prescaler, duty, {pin, source, enable}
    for (int k = 0; k < 3; k++) begin
      u = ({12'h0, cn[k]} + 20'h1) * (cc[k][1] ? 20'h1 : 20'h2);
      clr <= 1'b1;
      bus(PRE_OFS, 1'b1, {24'h0, cn[k]});
      bus(DUTY_OFS, 1'b1, {24'h0, cm[k]});
      clr <= 1'b0;
      bus(CTRL_OFS, 1'b1, {29'h0, cc[k]});
      repeat (2) pq.push_back({cm[k] * u, 20'd255 * u});
      if (k == 0) begin
        pq_wait(1);
        bus(DUTY_OFS, 1'b1, 32'h4);
        pq.push_back({20'h4 * u, 20'd255 * u});
      end
      pq_wait(0);
      bus(CTRL_OFS, 1'b1, 32'h0);
      $display("test pulse case %0d done", k);
    end
    test_done();
  end
endmodule

`default_nettype wire
